/* src/fabric_cells.sv */
module fabric_cells
  import fabric_pkg::*;
#(
  parameter bit IS_SIDE_CELL = 1'b1
)
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rstn,
  // cell pair configuration
  input  wire fabric_pkg::pair_type_t pair_type,
  input  wire fabric_pkg::seq_mode_t  seq_mode_a,
  input  wire fabric_pkg::seq_mode_t  seq_mode_b,
  // cell pair inputs, two cells of ten bits each
  input  wire logic [3:0]            cell_data_a,
  input  wire logic [3:0]            cell_sel_a,
  input  wire logic [3:0]            cell_data_b,
  input  wire logic [3:0]            cell_sel_b,
  input  wire logic                  cell_clear_a,
  input  wire logic                  cell_clear_b,
  input  wire logic                  cell_gate_a,
  input  wire logic                  cell_gate_b,
  // cell pair outputs
  output      logic                  cell_y_a,
  output      logic                  cell_y_b,
  // io cell user side
  input  wire logic                  user_out_upper,
  input  wire logic                  user_out_lower,
  input  wire logic                  user_out_pick_lower,
  input  wire logic                  io_enable,
  input  wire logic                  output_latch_gate,
  input  wire logic                  global_input_disable,
  input  wire logic                  global_output_disable,
  output      logic                  io_y,
  // pad side
  output      logic                  pad_drive_line,
  output      logic                  pad_drive_oe,
  input  wire logic                  pad_receive_line,
  // clock pads
  input  wire logic                  global_clock_pad_first,
  input  wire logic                  global_clock_pad_second,
  output      logic                  global_clock_net_first,
  output      logic                  global_clock_net_second
);
  import fabric_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [1:0] store;
    logic       out_latch;
    logic [1:0] pad_sync;
    logic       in_latch;
    logic [1:0] global_clock_pad_first_sync;
    logic [1:0] global_clock_pad_second_sync;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ----------------------------------------------------------------
  // cell pair
  // ----------------------------------------------------------------
  logic [1:0] is_seq;
  logic [1:0] func;
  logic [1:0] seq_out;
  logic [1:0] gate_v;
  logic [1:0] clear_v;
  logic [1:0] clear_ok;
  logic [1:0] latch_v;
  logic [1:0] comb_v;
  seq_mode_t  mode_v [2];
  logic [3:0] data_v [2];
  logic [3:0] sel_v  [2];

  assign is_seq  = {pair_type == PAIR_CS || pair_type == PAIR_SS,
                    pair_type == PAIR_SC || pair_type == PAIR_SS};
  assign mode_v[0] = seq_mode_a;
  assign mode_v[1] = seq_mode_b;
  assign data_v[0] = cell_data_a;
  assign data_v[1] = cell_data_b;
  assign sel_v[0]  = cell_sel_a;
  assign sel_v[1]  = cell_sel_b;
  assign gate_v    = {cell_gate_b, cell_gate_a};
  assign clear_v   = {cell_clear_b, cell_clear_a};

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_cell
      logic sel_b_eff;
      // in a storing sequential cell the second AND input is the clear line;
      // the fully combinational mode needs it back to offer all eight inputs
      assign sel_b_eff = (is_seq[i] && mode_v[i] != SEQ_COMB) ? 1'b1 : sel_v[i][1];
      comb_cell u_cell
      (
        .data_in            (data_v[i]),
        .first_select_in_a  (sel_v[i][0]),
        .first_select_in_b  (sel_b_eff),
        .second_select_in_a (sel_v[i][2]),
        .second_select_in_b (sel_v[i][3]),
        .y                  (func[i])
      );
      assign clear_ok[i] = is_seq[i] && (mode_v[i] == SEQ_FLOP_CLR ||
                                         mode_v[i] == SEQ_LATCH_CLR) && clear_v[i];
      assign latch_v[i]  = is_seq[i] && (mode_v[i] == SEQ_LATCH_CLR || mode_v[i] == SEQ_LATCH);
      assign comb_v[i]   = !is_seq[i] || mode_v[i] == SEQ_COMB;
      // a latch is modelled as transparent in the gate-high cycle
      always_comb
      begin
        if (clear_ok[i])
          seq_out[i] = CLEAR_VALUE;
        else if (comb_v[i] || (latch_v[i] && gate_v[i]))
          seq_out[i] = func[i];
        else
          seq_out[i] = state_r.store[i];
      end
    end
  endgenerate

  assign cell_y_a = seq_out[0];
  assign cell_y_b = seq_out[1];

  // ----------------------------------------------------------------
  // io cell
  // ----------------------------------------------------------------
  logic user_data;
  logic out_latch_q;
  logic input_latch_gate;
  logic pad_in_q;

  assign user_data        = (IS_SIDE_CELL && user_out_pick_lower) ? user_out_lower : user_out_upper;
  assign out_latch_q      = output_latch_gate ? user_data : state_r.out_latch;
  assign input_latch_gate = !output_latch_gate;
  assign pad_in_q         = global_input_disable ? 1'b0 : state_r.pad_sync[1];
  // special pads need no extra logic: this cell serves them in user mode
  assign pad_drive_line   = out_latch_q;
  assign pad_drive_oe     = io_enable && !global_output_disable;
  assign io_y             = input_latch_gate ? state_r.in_latch : pad_in_q;

  // clock pads also go to the global networks, after synchronising
  assign global_clock_net_first  = state_r.global_clock_pad_first_sync[1];
  assign global_clock_net_second = state_r.global_clock_pad_second_sync[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    for (int k = 0; k < 2; k++)
    begin
      if (clear_ok[k])
        state_nxt.store[k] = CLEAR_VALUE;
      else if (is_seq[k] && mode_v[k] == SEQ_FLOP_CLR)
        state_nxt.store[k] = func[k];
      else if (latch_v[k] && gate_v[k])
        state_nxt.store[k] = func[k];
    end
    state_nxt.out_latch = out_latch_q;
    state_nxt.pad_sync  = {state_r.pad_sync[0], pad_receive_line};
    state_nxt.in_latch  = input_latch_gate ? state_r.in_latch : pad_in_q;
    state_nxt.global_clock_pad_first_sync = {state_r.global_clock_pad_first_sync[0], global_clock_pad_first};
    state_nxt.global_clock_pad_second_sync = {state_r.global_clock_pad_second_sync[0], global_clock_pad_second};
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_r           <= '0;
      state_r.store     <= {STORE_RESET, STORE_RESET};
      state_r.out_latch <= IO_LATCH_INIT;
      state_r.in_latch  <= IO_LATCH_INIT;
    end
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_clear_zero: assert property (@(posedge clock) disable iff (!rstn)
    clear_ok[0] |-> ##1 (state_r.store[0] == 1'b0)) else $error("clear did not zero store");
  a_flop_capture: assert property (@(posedge clock) disable iff (!rstn)
    (is_seq[0] && seq_mode_a == SEQ_FLOP_CLR && !cell_clear_a) |=> (state_r.store[0] == $past(func[0])))
    else $error("flop did not capture");
  a_comb_pass: assert property (@(posedge clock) disable iff (!rstn)
    !is_seq[1] |-> (cell_y_b == func[1])) else $error("comb cell not transparent");
  a_oe_follow: assert property (@(posedge clock) disable iff (!rstn)
    pad_drive_oe == (io_enable && !global_output_disable)) else $error("enable mismatch");
  a_out_disable: assert property (@(posedge clock) disable iff (!rstn)
    global_output_disable |-> !pad_drive_oe) else $error("output not disabled");
  a_out_hold: assert property (@(posedge clock) disable iff (!rstn)
    (!output_latch_gate && $past(!output_latch_gate)) |-> $stable(pad_drive_line))
    else $error("output latch not holding");
  a_in_hold: assert property (@(posedge clock) disable iff (!rstn)
    (!output_latch_gate && $past(!output_latch_gate)) |-> $stable(io_y)) else $error("input latch not holding");
  a_in_pass: assert property (@(posedge clock) disable iff (!rstn)
    (output_latch_gate && !global_input_disable) |-> (io_y == state_r.pad_sync[1]))
    else $error("input latch not transparent");
  a_clk_net: assert property (@(posedge clock) disable iff (!rstn)
    global_clock_pad_first ##1 global_clock_pad_first |=> global_clock_net_first)
    else $error("clock pad not reaching net");
endmodule // fabric_cells

/* src/fabric_pkg.sv */
package fabric_pkg;

  // ----------------------------------------------------------------
  // sequential stage configurations
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEQ_FLOP_CLR  = 2'b00,  // 7-input function plus clearable flip-flop
    SEQ_LATCH_CLR = 2'b01,  // 7-input function plus clearable latch
    SEQ_LATCH     = 2'b10,  // 7-input function plus latch
    SEQ_COMB      = 2'b11   // 8-input function, storage transparent
  } seq_mode_t;

  // ----------------------------------------------------------------
  // reset and clear values
  // ----------------------------------------------------------------
  localparam logic STORE_RESET   = 1'b0;
  localparam logic CLEAR_VALUE   = 1'b0;
  localparam logic IO_LATCH_INIT = 1'b0;

  // ----------------------------------------------------------------
  // cell pair types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PAIR_CC = 2'b00,
    PAIR_CS = 2'b01,
    PAIR_SC = 2'b10,
    PAIR_SS = 2'b11
  } pair_type_t;

endpackage : fabric_pkg

/* src/comb_cell.sv */
module comb_cell
(
  // data inputs
  input  wire logic [3:0] data_in,
  // select inputs
  input  wire logic       first_select_in_a,
  input  wire logic       first_select_in_b,
  input  wire logic       second_select_in_a,
  input  wire logic       second_select_in_b,
  // result
  output      logic       y
);
  logic first_select_term;
  logic second_select_term;

  assign first_select_term  = first_select_in_a & first_select_in_b;
  assign second_select_term = second_select_in_a | second_select_in_b;
  assign y = data_in[{second_select_term, first_select_term}];
endmodule // comb_cell

/* verif/pad_board.sv */
module pad_board
(
  // clock
  input  wire logic clock,
  // device side
  input  wire logic pad_drive_line,
  input  wire logic pad_drive_oe,
  output      logic pad_receive_line,
  // board side
  input  wire logic board_en,
  input  wire logic board_value,
  output      logic mode_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic float_r;
  assign mode_pin = 1'b0;
  initial
    float_r = 1'b0;
  // a released wire wanders so a stale level never looks valid
  always @(posedge clock)
    float_r <= ~pad_receive_line;
  assign pad_receive_line = pad_drive_oe ? pad_drive_line : (board_en ? board_value : float_r);
endmodule // pad_board

/* verif/tb_fabric_cells.sv */
module tb_fabric_cells import fabric_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, rstn, cell_clear_a, cell_clear_b, cell_gate_a, cell_gate_b, cell_y_a, cell_y_b;
  logic [3:0] cell_data_a, cell_sel_a, cell_data_b, cell_sel_b;
  logic       user_out_upper, user_out_lower, user_out_pick_lower, io_enable, output_latch_gate, io_y;
  logic       global_input_disable, global_output_disable, board_en, board_value;
  logic       pad_drive_line, pad_drive_oe, pad_receive_line;
  logic       global_clock_pad_first, global_clock_pad_second, global_clock_net_first, global_clock_net_second;
  pair_type_t pair_type;
  seq_mode_t  seq_mode_a, seq_mode_b;
  int         errors, checks_done;

  fabric_cells #(.IS_SIDE_CELL(1'b1)) uut (.clock, .rstn, .pair_type, .seq_mode_a, .seq_mode_b,
    .cell_data_a, .cell_sel_a, .cell_data_b, .cell_sel_b, .cell_clear_a, .cell_clear_b,
    .cell_gate_a, .cell_gate_b, .cell_y_a, .cell_y_b, .user_out_upper, .user_out_lower,
    .user_out_pick_lower, .io_enable, .output_latch_gate, .global_input_disable,
    .global_output_disable, .io_y, .pad_drive_line, .pad_drive_oe, .pad_receive_line,
    .global_clock_pad_first, .global_clock_pad_second, .global_clock_net_first, .global_clock_net_second);
  pad_board board (.clock, .pad_drive_line, .pad_drive_oe, .pad_receive_line, .board_en, .board_value,
    .mode_pin());

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic edges(input int n);
    repeat (n) @(negedge clock);
  endtask

  // a storing sequential cell loses the and-term because its partner input is the clear
  function automatic logic pick(input logic [3:0] d, input logic [3:0] s, input logic seq);
    return d[{s[2] | s[3], seq ? s[0] : s[0] & s[1]}];
  endfunction

  task automatic final_report();
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    #20000;
    errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    checks_done = 0;
    pair_type = PAIR_SS;
    seq_mode_a = SEQ_FLOP_CLR;
    seq_mode_b = SEQ_COMB;
    {rstn, cell_clear_a, cell_clear_b, cell_gate_a, cell_gate_b, cell_sel_a, cell_sel_b} = '0;
    {user_out_upper, user_out_lower, user_out_pick_lower, io_enable, output_latch_gate} = '0;
    {global_input_disable, global_output_disable, board_en, board_value} = '0;
    {global_clock_pad_first, global_clock_pad_second} = '0;
    cell_data_a = 4'hf;
    cell_data_b = 4'h0;
    edges(12);
    rstn = 1'b1;
    #1 chk("flop reset", STORE_RESET, cell_y_a);
    edges(1);
    chk("flop store", 1'b1, cell_y_a);
    cell_clear_a = 1'b1;
    #1 chk("flop clear", CLEAR_VALUE, cell_y_a);
    edges(1);
    chk("flop clear held", CLEAR_VALUE, cell_y_a);
    seq_mode_a = SEQ_LATCH_CLR;
    cell_gate_a = 1'b1;
    #1 chk("latch clear", CLEAR_VALUE, cell_y_a);
    edges(1);
    seq_mode_a = SEQ_LATCH;
    #1 chk("latch ignores clear", 1'b1, cell_y_a);
    edges(1);
    cell_gate_a = 1'b0;
    cell_data_a = 4'h0;
    #1 chk("latch hold", 1'b1, cell_y_a);
    edges(1);
    cell_gate_a = 1'b1;
    #1 chk("latch open", 1'b0, cell_y_a);
    // cell a is sequential in SC and SS, cell b in CS and SS; open latches show the function
    for (int k = 0; k < 256; k++)
    begin
      edges(1);
      pair_type = pair_type_t'(k[6:5]);
      seq_mode_a = seq_mode_t'({1'b1, k[7]});
      seq_mode_b = seq_mode_t'({1'b1, k[7]});
      {cell_clear_b, cell_gate_b} = 2'b11;
      cell_data_a = k[4] ? 4'h9 : 4'h6;
      cell_data_b = ~cell_data_a;
      cell_sel_a = k[3:0];
      cell_sel_b = ~k[3:0];
      #1 chk("cell_y_a", pick(cell_data_a, cell_sel_a, k[6] && !k[7]), cell_y_a);
      chk("cell_y_b", pick(cell_data_b, cell_sel_b, k[5] && !k[7]), cell_y_b);
    end
    edges(1);
    io_enable = 1'b1;
    output_latch_gate = 1'b1;
    user_out_upper = 1'b1;
    #1 chk("pad drive upper", 1'b1, pad_drive_line);
    edges(1);
    user_out_pick_lower = 1'b1;
    #1 chk("pad drive lower", 1'b0, pad_drive_line);
    edges(1);
    output_latch_gate = 1'b0;
    user_out_lower = 1'b1;
    #1 chk("output latch hold", 1'b0, pad_drive_line);
    for (int k = 0; k < 4; k++)
    begin
      edges(1);
      io_enable = k[0];
      global_output_disable = k[1];
      #1 chk("pad_drive_oe", k == 1, pad_drive_oe);
    end
    edges(1);
    {board_en, board_value} = 2'b11;
    output_latch_gate = 1'b1;
    edges(4);
    chk("io_y open", 1'b1, io_y);
    output_latch_gate = 1'b0;
    board_value = 1'b0;
    edges(4);
    chk("io_y held", 1'b1, io_y);
    output_latch_gate = 1'b1;
    edges(4);
    chk("io_y follows", 1'b0, io_y);
    board_value = 1'b1;
    global_input_disable = 1'b1;
    edges(4);
    chk("io_y disabled", 1'b0, io_y);
    for (int k = 1; k < 3; k++)
    begin
      {global_clock_pad_second, global_clock_pad_first} = k[1:0];
      edges(4);
      chk("clock net first", k[0], global_clock_net_first);
      chk("clock net second", k[1], global_clock_net_second);
    end
    final_report();
  end
endmodule // tb_fabric_cells
